// ### logic/lcc_core.sv
// Control logic of a single-cell linear charger
`timescale 1ns/1ps
`include "lcc_params.svh"
module lcc_core #(
	parameter int TICK_CYC = `LCC_CLK_HZ * `LCC_TICK_S
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Auto start and power
	input  wire logic        auto_start_input,
	input  wire logic        power_good,
	// Regulation conditions
	input  wire logic        input_voltage_foldback,
	input  wire logic        thermal_regulation,
	// Programming and measured output current
	input  wire logic [10:0] fast_current_program,
	input  wire logic        fast_current_short,
	input  wire logic [10:0] output_current,
	input  wire logic [5:0]  precharge_term_program,
	input  wire logic        precharge_term_open,
	input  wire logic [1:0]  input_limit_select,
	// Temperature sense comparators
	input  wire logic        ts_pulled_low,
	input  wire logic        ts_high,
	input  wire logic        temp_below_0,
	input  wire logic        temp_below_10,
	input  wire logic        temp_above_45,
	input  wire logic        temp_above_60,
	// Battery and output comparators
	input  wire logic        battery_charge_disable,
	input  wire logic        below_precharge_exit,
	input  wire logic        above_recharge_threshold,
	input  wire logic        current_at_term,
	input  wire logic        battery_present,
	// Outputs
	output logic             auto_start_output,
	output logic [10:0]      current_limit,
	output logic [10:0]      term_current,
	output logic             reg_voltage_reduced,
	output logic             charge_enable,
	output logic             charge_status_indicator_oe,
	output logic             battery_detect_run,
	output logic             timer_expired,
	output logic             short_latched,
	output lcc_pkg::lcc_state_t state
);
	logic        tick;       // Time-base tick
	logic        half_phase; // Alternate-tick phase
	logic        term_timer_disable_mode_prev;  // Mode flag last cycle
	logic        first_chg;  // First charge cycle
	logic        ind_keep;   // Indicator allowed
	logic [15:0] tmr;        // Safety timer, ticks
	logic [10:0] fold_cut;   // Foldback reduction
	logic        next_half;
	logic        next_term_timer_disable_mode_prev;
	logic        next_first;
	logic [15:0] next_tmr;
	logic [10:0] next_fold;
	logic        next_aso;
	logic [10:0] next_limit;
	logic [10:0] next_term;
	logic        next_vred;
	logic        next_en;
	logic        next_oe;
	logic        next_det;
	logic        next_exp;
	logic        next_short;
	lcc_pkg::lcc_state_t next_state;
	// Decoded flags
	logic        term_timer_disable_mode;
	logic        ts_fault;
	logic        disabled;
	logic        slow;
	logic        acc_tick;
	logic        term_timer_disable_mode_edge;
	logic [10:0] prog;
	logic [10:0] base;
	logic [5:0]  pct;
	logic [10:0] pre_cur;
	logic        charging;

	// Clamp a value into a range
	function automatic logic [10:0] clamp11(input logic [10:0] v, input logic [10:0] lo,
		input logic [10:0] hi);
		clamp11 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Percentage of the programmed current
	function automatic logic [10:0] pct_of(input logic [10:0] cur, input logic [5:0] p);
		logic [17:0] prod;
		prod = 18'(cur) * 18'(p);
		pct_of = 11'(prod / `LCC_PCT_DIV);
	endfunction

	lcc_tick_gen #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.clock (clock),
		.rst   (rst),
		.tick  (tick)
	);

	// Flag decoding, all synchronous levels
	always_comb begin
		term_timer_disable_mode = ts_high && !ts_pulled_low;
		ts_fault = ts_pulled_low || temp_below_0 || temp_above_60;
		disabled = battery_charge_disable || (!term_timer_disable_mode && ts_fault) || !power_good;
		slow = thermal_regulation || input_voltage_foldback ||
			(input_limit_select == `LCC_SEL_FLOAT);
		acc_tick = tick && (!slow || half_phase);
		term_timer_disable_mode_edge = term_timer_disable_mode != term_timer_disable_mode_prev;
		prog = clamp11(fast_current_program, `LCC_MIN_MA, `LCC_MAX_MA);
		pct = precharge_term_open ? `LCC_TERM_DEF_PCT :
			6'(clamp11(11'(precharge_term_program), 11'(`LCC_TERM_MIN_PCT),
			11'(`LCC_TERM_MAX_PCT)));
		case (input_limit_select)
			`LCC_SEL_FLOAT: base = (prog < `LCC_USB_LOW_MA) ? prog : `LCC_USB_LOW_MA;
			`LCC_SEL_HIGH: base = (prog < `LCC_USB_HIGH_MA) ? prog : `LCC_USB_HIGH_MA;
			default: base = prog;
		endcase
		pre_cur = 11'(pct_of(prog, pct) << 1);
	end

	// State machine and timer next values
	always_comb begin
		next_state = state;
		next_tmr = tmr;
		next_first = first_chg;
		next_short = short_latched;
		next_exp = timer_expired;
		next_half = (tick && slow) ? !half_phase : half_phase;
		next_term_timer_disable_mode_prev = term_timer_disable_mode;
		if (fast_current_short && output_current >= `LCC_SHORT_MIN_MA) begin
			next_short = 1'b1;
		end
		if (acc_tick && !(term_timer_disable_mode && state != lcc_pkg::LCC_PRE)) begin
			next_tmr = tmr + 16'h0001;
		end
		case (state)
			lcc_pkg::LCC_PRE: begin
				if (!below_precharge_exit) begin
					next_state = lcc_pkg::LCC_FAST;
					next_tmr = 16'h0000;
				end else if (tmr >= 16'(`LCC_PRE_TICKS)) begin
					next_state = lcc_pkg::LCC_FAULT;
					next_exp = 1'b1;
				end
			end
			lcc_pkg::LCC_FAST, lcc_pkg::LCC_HOLD: begin
				if (!term_timer_disable_mode && tmr >= 16'(`LCC_FAST_TICKS)) begin
					next_state = lcc_pkg::LCC_FAULT;
					next_exp = 1'b1;
				end else if (above_recharge_threshold) begin
					next_state = lcc_pkg::LCC_HOLD;
					if (current_at_term) begin
						next_first = 1'b0;
						if (!term_timer_disable_mode && battery_present) begin
							next_state = lcc_pkg::LCC_DONE;
						end
					end
				end else begin
					next_state = lcc_pkg::LCC_FAST;
				end
			end
			lcc_pkg::LCC_DONE: begin
				if (!above_recharge_threshold || !battery_present) begin
					next_state = lcc_pkg::LCC_PRE;
					next_tmr = 16'h0000;
				end
			end
			lcc_pkg::LCC_DIS: begin
				if (!disabled) begin
					next_state = lcc_pkg::LCC_PRE;
					next_first = 1'b1;
				end
			end
			lcc_pkg::LCC_FAULT: begin
				next_state = lcc_pkg::LCC_FAULT;
			end
			default: next_state = lcc_pkg::LCC_DIS;
		endcase
		// Mode entry or exit restarts the cycle
		if (term_timer_disable_mode_edge) begin
			next_tmr = 16'h0000;
			next_exp = 1'b0;
			next_state = lcc_pkg::LCC_PRE;
			if (!term_timer_disable_mode && battery_present) begin
				next_first = 1'b1;
			end
		end
		// Priority: short latch, then disable
		if (next_short) begin
			next_state = lcc_pkg::LCC_FAULT;
		end else if (disabled) begin
			next_state = lcc_pkg::LCC_DIS;
			next_tmr = 16'h0000;
			next_exp = 1'b0;
		end
		if (!battery_present && !term_timer_disable_mode) begin
			next_first = 1'b0;
		end
		if (term_timer_disable_mode && !battery_present) begin
			next_first = 1'b0;
		end
	end

	// State machine registers; reset stands for a power cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= lcc_pkg::LCC_DIS;
			tmr <= 16'h0000;
			first_chg <= 1'b1;
			short_latched <= 1'b0;
			timer_expired <= 1'b0;
			half_phase <= 1'b0;
			term_timer_disable_mode_prev <= 1'b0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			first_chg <= next_first;
			short_latched <= next_short;
			timer_expired <= next_exp;
			half_phase <= next_half;
			term_timer_disable_mode_prev <= next_term_timer_disable_mode_prev;
		end
	end

	// Output next values
	always_comb begin
		charging = (state == lcc_pkg::LCC_PRE) || (state == lcc_pkg::LCC_FAST) ||
			(state == lcc_pkg::LCC_HOLD);
		next_aso = auto_start_input || power_good;
		next_fold = fold_cut;
		if (tick) begin
			if (input_voltage_foldback) begin
				next_fold = (fold_cut < base) ? fold_cut + `LCC_FOLD_STEP_MA : base;
			end else begin
				next_fold = (fold_cut > `LCC_FOLD_STEP_MA) ?
					fold_cut - `LCC_FOLD_STEP_MA : 11'h000;
			end
		end
		if (!input_voltage_foldback && fold_cut > base) begin
			next_fold = base;
		end
		next_limit = (state == lcc_pkg::LCC_PRE && pre_cur < base) ? pre_cur : base;
		if (temp_below_10 && !temp_below_0) begin
			next_limit = next_limit >> 1;
		end
		next_limit = (next_limit > fold_cut) ? next_limit - fold_cut : 11'h000;
		if (!charging) begin
			next_limit = 11'h000;
		end
		next_term = pct_of(prog, pct);
		next_vred = temp_above_45 && !temp_above_60;
		next_en = charging;
		ind_keep = first_chg && charging && battery_present;
		next_oe = ind_keep;
		next_det = term_timer_disable_mode_edge ||
			(!term_timer_disable_mode && !ts_fault &&
			((state == lcc_pkg::LCC_HOLD && current_at_term) ||
			!battery_present));
	end

	// Output registers
	always_ff @(posedge clock) begin
		if (rst) begin
			auto_start_output <= 1'b0;
			current_limit <= 11'h000;
			term_current <= 11'h000;
			reg_voltage_reduced <= 1'b0;
			charge_enable <= 1'b0;
			charge_status_indicator_oe <= 1'b0;
			battery_detect_run <= 1'b0;
			fold_cut <= 11'h000;
		end else begin
			auto_start_output <= next_aso;
			current_limit <= next_limit;
			term_current <= next_term;
			reg_voltage_reduced <= next_vred;
			charge_enable <= next_en;
			charge_status_indicator_oe <= next_oe;
			battery_detect_run <= next_det;
			fold_cut <= next_fold;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence short_seen;
		fast_current_short && output_current >= `LCC_SHORT_MIN_MA;
	endsequence
	sequence mode_flip;
		term_timer_disable_mode != $past(term_timer_disable_mode);
	endsequence

	aso_follows_a: assert property (!rst |=>
		auto_start_output == $past(auto_start_input || power_good))
		else $error("auto start output wrong");
	short_latch_a: assert property (short_seen |=> short_latched ##1 state == lcc_pkg::LCC_FAULT)
		else $error("short not latched");
	short_hold_a: assert property (short_latched |=> short_latched)
		else $error("short latch cleared");
	limit_cap_a: assert property (current_limit <= `LCC_MAX_MA)
		else $error("limit above maximum");
	usb_low_a: assert property (input_limit_select == `LCC_SEL_FLOAT &&
		!$past(rst) |=> current_limit <= `LCC_USB_LOW_MA)
		else $error("float select not capped");
	temp_off_a: assert property ((temp_above_60 || ts_pulled_low) && !fast_current_short &&
		!short_latched |=>
		state == lcc_pkg::LCC_DIS ##1 !charge_enable)
		else $error("hot or pulled low not disabled");
	warm_volt_a: assert property (temp_above_45 && !temp_above_60 |=> reg_voltage_reduced)
		else $error("warm zone not reduced");
	mode_reset_a: assert property (mode_flip and !disabled and !next_short |=> tmr == 16'h0000)
		else $error("timer not reset on mode change");
	expire_off_a: assert property (timer_expired |=> !charge_enable && !charge_status_indicator_oe)
		else $error("expired but still charging");
	det_quiet_a: assert property (term_timer_disable_mode && term_timer_disable_mode_prev |=> !battery_detect_run)
		else $error("detect ran in mode");
endmodule

// ### logic/lcc_params.svh
// Constants shared by the linear charger control block
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

`define LCC_CLK_HZ        40000000
`define LCC_TICK_S        1
`define LCC_PRE_TIME_MIN  30
`define LCC_FAST_TIME_H   10
`define LCC_PRE_TICKS     (`LCC_PRE_TIME_MIN * 60 / `LCC_TICK_S)
`define LCC_FAST_TICKS    (`LCC_FAST_TIME_H * 3600 / `LCC_TICK_S)
`define LCC_MIN_MA        11'h032
`define LCC_MAX_MA        11'h3E8
`define LCC_USB_LOW_MA    11'h064
`define LCC_USB_HIGH_MA   11'h1F4
`define LCC_SHORT_MIN_MA  11'h050
`define LCC_TERM_MIN_PCT  6'h05
`define LCC_TERM_MAX_PCT  6'h32
`define LCC_TERM_DEF_PCT  6'h0A
`define LCC_PCT_DIV       18'h00064
`define LCC_FOLD_STEP_MA  11'h00A
`define LCC_SEL_LOW       2'h0
`define LCC_SEL_FLOAT     2'h1
`define LCC_SEL_HIGH      2'h2

`endif

// ### logic/lcc_pkg.sv
// Types of the linear charger control block
package lcc_pkg;
	// Charge state machine, binary codes
	typedef enum logic [2:0] {
		LCC_PRE   = 3'h0,
		LCC_FAST  = 3'h1,
		LCC_HOLD  = 3'h2,
		LCC_DONE  = 3'h3,
		LCC_DIS   = 3'h4,
		LCC_FAULT = 3'h5
	} lcc_state_t;
endpackage

// ### logic/lcc_tick_gen.sv
// Free-running time base for the safety timers
`timescale 1ns/1ps
`include "lcc_params.svh"
module lcc_tick_gen #(
	parameter int TICK_CYC = `LCC_CLK_HZ * `LCC_TICK_S
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// One-cycle tick
	output logic      tick
);
	logic [31:0] cnt;       // Cycle counter
	logic [31:0] next_cnt;  // Next count
	logic        next_tick; // Next tick

	// Wrap at the tick period
	always_comb begin
		next_cnt = cnt + 32'h00000001;
		next_tick = 1'b0;
		if (cnt >= 32'(TICK_CYC - 1)) begin
			next_cnt = 32'h00000000;
			next_tick = 1'b1;
		end
	end

	// Registers
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt <= 32'h00000000;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// ### tb/lcc_batt_model.sv
// Behavioural cell, source and host monitor on the charger's far side
`timescale 1ns/1ps
module lcc_batt_model (
	// Controls from the bench
	input  wire logic [12:0] bat_mv,
	input  wire logic        bat_in,
	// Charger side
	input  wire logic        charge_enable,
	input  wire logic [10:0] current_limit,
	input  wire logic        charge_status_indicator_oe,
	// Comparator results back to the charger
	output logic             below_precharge_exit,
	output logic             above_recharge_threshold,
	output logic             current_at_term,
	output logic             battery_present,
	output logic [10:0]      output_current,
	// Indicator line as the host sees it
	output logic             indicator_level
);
	// Cell thresholds in mV
	localparam logic [12:0] PRE_EXIT_MV = 13'h09C4;
	localparam logic [12:0] RECHG_MV    = 13'h1004;
	localparam logic [12:0] FULL_MV     = 13'h1068;
	// Comparators; a full cell is taken to have tapered already
	always_comb begin
		below_precharge_exit     = bat_mv < PRE_EXIT_MV;
		above_recharge_threshold = bat_mv > RECHG_MV;
		current_at_term          = bat_mv >= FULL_MV;
		battery_present          = bat_in;
		// Cell sinks the whole limit, worst case for the short check
		output_current = charge_enable ? current_limit : 11'h000;
		// Pull-up wins once the open drain lets go
		indicator_level = ~charge_status_indicator_oe;
	end
endmodule

// ### tb/linear_charger_control_fsm_tb_top.sv
// Self-checking bench for the linear charger control block
`timescale 1ns/1ps
module linear_charger_control_fsm_tb_top;
	// Clock, reset, verdict counters
	logic clock = 1'b0;
	logic rst = 1'b1;
	int   n_fail = 0;
	int   total_checks = 0;
	// Stimulus, all given a value at time zero
	logic        auto_start_input = 1'b0, power_good = 1'b0, thermal_regulation = 1'b0;
	logic        input_voltage_foldback = 1'b0, fast_current_short = 1'b0;
	logic [10:0] fast_current_program = 11'h320;
	logic [5:0]  precharge_term_program = 6'h0A;
	logic        precharge_term_open = 1'b0, ts_pulled_low = 1'b0, ts_high = 1'b0;
	logic        temp_below_0 = 1'b0, temp_below_10 = 1'b0, temp_above_45 = 1'b0;
	logic        temp_above_60 = 1'b0, battery_charge_disable = 1'b0, bat_in = 1'b1;
	logic [1:0]  input_limit_select = 2'h0;
	logic [12:0] bat_mv = 13'h07D0;
	// Partner and design outputs
	logic        below_precharge_exit, above_recharge_threshold, current_at_term;
	logic        battery_present, indicator_level, auto_start_output, reg_voltage_reduced;
	logic        charge_enable, charge_status_indicator_oe, battery_detect_run;
	logic        timer_expired, short_latched;
	logic [10:0] output_current, current_limit, term_current;
	lcc_pkg::lcc_state_t state;

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// Short time base so the safety timers fit the run
	lcc_core #(.TICK_CYC(4)) uut (.clock(clock), .rst(rst),
		.auto_start_input(auto_start_input), .power_good(power_good),
		.input_voltage_foldback(input_voltage_foldback),
		.thermal_regulation(thermal_regulation), .fast_current_program(fast_current_program),
		.fast_current_short(fast_current_short), .output_current(output_current),
		.precharge_term_program(precharge_term_program),
		.precharge_term_open(precharge_term_open), .input_limit_select(input_limit_select),
		.ts_pulled_low(ts_pulled_low), .ts_high(ts_high), .temp_below_0(temp_below_0),
		.temp_below_10(temp_below_10), .temp_above_45(temp_above_45),
		.temp_above_60(temp_above_60), .battery_charge_disable(battery_charge_disable),
		.below_precharge_exit(below_precharge_exit),
		.above_recharge_threshold(above_recharge_threshold),
		.current_at_term(current_at_term), .battery_present(battery_present),
		.auto_start_output(auto_start_output), .current_limit(current_limit),
		.term_current(term_current), .reg_voltage_reduced(reg_voltage_reduced),
		.charge_enable(charge_enable),
		.charge_status_indicator_oe(charge_status_indicator_oe),
		.battery_detect_run(battery_detect_run), .timer_expired(timer_expired),
		.short_latched(short_latched), .state(state));

	// Far side: cell, source and host pull-up
	lcc_batt_model model (.bat_mv(bat_mv), .bat_in(bat_in), .charge_enable(charge_enable),
		.current_limit(current_limit),
		.charge_status_indicator_oe(charge_status_indicator_oe),
		.below_precharge_exit(below_precharge_exit),
		.above_recharge_threshold(above_recharge_threshold),
		.current_at_term(current_at_term), .battery_present(battery_present),
		.output_current(output_current), .indicator_level(indicator_level));

	// Print counts and verdict, then stop
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Case-equal compare, zero extension keeps unknowns visible
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Sample away from the driving edge
	task automatic settle(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Bounded wait for a state, then judge it
	task automatic wait_state(input lcc_pkg::lcc_state_t s, input int lim);
		int i;
		for (i = 0; i < lim && state !== s; i++)
			@(negedge clock);
		chk("state", 11'(s), 11'(state));
	endtask

	// Power cycle with defaults: 800 mA, 10 percent, cool-free, sensor normal
	task automatic start(input logic [12:0] mv);
		@(posedge clock);
		rst <= 1'b1;
		power_good <= 1'b1;
		bat_mv <= mv;
		bat_in <= 1'b1;
		fast_current_program <= 11'h320;
		precharge_term_program <= 6'h0A;
		{precharge_term_open, ts_pulled_low, ts_high, thermal_regulation} <= 4'h0;
		{temp_below_0, temp_below_10, temp_above_45, temp_above_60} <= 4'h0;
		{battery_charge_disable, fast_current_short, input_voltage_foldback} <= 3'h0;
		input_limit_select <= 2'h0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
	endtask

	// OR of the two start sources, every combination
	task automatic t_auto();
		int k;
		for (k = 0; k < 4; k++) begin
			@(posedge clock);
			auto_start_input <= k[0];
			power_good <= k[1];
			settle(2);
			chk("auto_start_output", 11'(k[0] | k[1]), 11'(auto_start_output));
		end
		@(posedge clock);
		auto_start_input <= 1'b0;
	endtask

	// Apply one setting from the fast-charge state, judge the limit
	task automatic lim_at(input logic [1:0] sel, input logic cool, input logic [10:0] exp);
		@(posedge clock);
		input_limit_select <= sel;
		temp_below_10 <= cool;
		settle(4);
		chk("current_limit", exp, current_limit);
	endtask

	// Precharge and fast levels, select states, zones, clamps
	task automatic t_levels();
		start(13'h07D0);
		wait_state(lcc_pkg::LCC_PRE, 10);
		settle(2);
		chk("term_current", 11'h050, term_current);
		chk("precharge limit", 11'h0A0, current_limit);
		chk("indicator", 11'h000, 11'(indicator_level));
		@(posedge clock);
		bat_mv <= 13'h0BB8;
		wait_state(lcc_pkg::LCC_FAST, 10);
		lim_at(2'h0, 1'b0, 11'h320);
		lim_at(2'h1, 1'b0, 11'h064);
		lim_at(2'h2, 1'b0, 11'h1F4);
		lim_at(2'h0, 1'b1, 11'h190);
		lim_at(2'h0, 1'b0, 11'h320);
		@(posedge clock);
		temp_above_45 <= 1'b1;
		settle(4);
		chk("reg_voltage_reduced", 11'h001, 11'(reg_voltage_reduced));
		chk("warm limit", 11'h320, current_limit);
		@(posedge clock);
		input_voltage_foldback <= 1'b1;
		settle(40);
		chk("foldback cut", 11'h001, 11'(current_limit < 11'h320));
		@(posedge clock);
		input_voltage_foldback <= 1'b0;
		fast_current_program <= 11'h7D0;
		settle(80);
		chk("clamp high", 11'h3E8, current_limit);
		@(posedge clock);
		fast_current_program <= 11'h014;
		settle(4);
		chk("clamp low", 11'h032, current_limit);
		@(posedge clock);
		fast_current_program <= 11'h320;
		precharge_term_program <= 6'h02;
		settle(4);
		chk("term floor", 11'h028, term_current);
		@(posedge clock);
		precharge_term_open <= 1'b1;
		settle(4);
		chk("term open", 11'h050, term_current);
	endtask

	// Each disabling condition other than power_good low is shown to stop charging
	task automatic t_disable();
		int k;
		for (k = 0; k < 4; k++) begin
			start(13'h0BB8);
			wait_state(lcc_pkg::LCC_FAST, 10);
			@(posedge clock);
			{temp_above_45, temp_above_60} <= {2{k == 0}};
			{temp_below_10, temp_below_0} <= {2{k == 1}};
			ts_pulled_low <= k == 2;
			battery_charge_disable <= k == 3;
			settle(4);
			chk("charge_enable", 11'h000, 11'(charge_enable));
			chk("idle limit", 11'h000, current_limit);
		end
	endtask

	// Termination, refresh and missing-cell detection
	task automatic t_term();
		start(13'h0BB8);
		wait_state(lcc_pkg::LCC_FAST, 10);
		@(posedge clock);
		bat_mv <= 13'h1068;
		wait_state(lcc_pkg::LCC_DONE, 10);
		settle(2);
		chk("charge_enable", 11'h000, 11'(charge_enable));
		chk("indicator", 11'h001, 11'(indicator_level));
		@(posedge clock);
		bat_mv <= 13'h0FD2;
		settle(6);
		chk("refresh charge", 11'h001, 11'(charge_enable));
		chk("refresh indicator", 11'h001, 11'(indicator_level));
		@(posedge clock);
		bat_mv <= 13'h1068;
		bat_in <= 1'b0;
		settle(6);
		chk("battery_detect_run", 11'h001, 11'(battery_detect_run));
	endtask

	// Timer-disable mode entry, missing cell, exit
	task automatic t_mode();
		start(13'h0BB8);
		wait_state(lcc_pkg::LCC_FAST, 10);
		@(posedge clock);
		ts_high <= 1'b1;
		bat_mv <= 13'h1068;
		settle(8);
		chk("charge in mode", 11'h001, 11'(charge_enable));
		@(posedge clock);
		bat_in <= 1'b0;
		settle(4);
		chk("indicator", 11'h001, 11'(indicator_level));
		chk("battery_detect_run", 11'h000, 11'(battery_detect_run));
		@(posedge clock);
		bat_in <= 1'b1;
		bat_mv <= 13'h0BB8;
		ts_high <= 1'b0;
		settle(6);
		chk("exit indicator", 11'h000, 11'(indicator_level));
		chk("exit charge", 11'h001, 11'(charge_enable));
	endtask

	// Program short latches until a power cycle
	task automatic t_short();
		start(13'h07D0);
		wait_state(lcc_pkg::LCC_PRE, 10);
		settle(2);
		@(posedge clock);
		fast_current_short <= 1'b1;
		settle(4);
		chk("short_latched", 11'h001, 11'(short_latched));
		@(posedge clock);
		fast_current_short <= 1'b0;
		settle(6);
		chk("latched off", 11'h000, 11'(charge_enable));
		start(13'h07D0);
		wait_state(lcc_pkg::LCC_PRE, 10);
		chk("short cleared", 11'h000, 11'(short_latched));
	endtask

	// Precharge timeout, at full or half rate; 1800 ticks of 4 cycles
	task automatic t_timer(input logic slow, input int lo, input int hi);
		int n;
		start(13'h07D0);
		thermal_regulation <= slow;
		wait_state(lcc_pkg::LCC_PRE, 10);
		for (n = 0; n < hi + 100 && timer_expired !== 1'b1; n++)
			@(negedge clock);
		chk("timeout window", 11'h001, 11'(n >= lo && n <= hi));
		settle(2);
		chk("expired charge", 11'h000, 11'(charge_enable));
		chk("expired indicator", 11'h001, 11'(indicator_level));
		@(posedge clock);
		battery_charge_disable <= 1'b1;
		settle(4);
		chk("timer reset", 11'h000, 11'(timer_expired));
	endtask

	// Hang guard, well past the longest expected run
	initial begin
		repeat (80000) @(posedge clock);
		n_fail++;
		finish_test();
	end

	// Main sequence
	initial begin
		start(13'h07D0);
		t_auto();
		t_levels();
		t_disable();
		t_term();
		t_mode();
		t_short();
		t_timer(1'b0, 7000, 7400);
		t_timer(1'b1, 14200, 14800);
		finish_test();
	end
endmodule
